// *** hw/eps_defines.svh ***
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define EPS_REG_CTRL_OFS 12'h000
`define EPS_REG_STATUS_OFS 12'h004

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define EPS_CTRL_OVR_BIT 0
`define EPS_CTRL_CODE_LSB 4
`define EPS_CTRL_OVR_RST 1'h0
`define EPS_CTRL_CODE_RST 3'h0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define EPS_STAT_CODE_LSB 0
`define EPS_STAT_INJ_LSB 4
`define EPS_STAT_DET_LSB 8
`define EPS_STAT_PIN_LSB 12

// ----------------------------------------
// Bus answers and widths
// ----------------------------------------
`define EPS_RESP_OKAY 2'h0
`define EPS_RESP_SLVERR 2'h2
`define EPS_CODE_W 3
`define EPS_MIN_ADDR_W 4

`endif

// *** hw/eps_pkg.sv ***
package eps_pkg;

  // ----------------------------------------
  // Configuration codes from the controller
  // ----------------------------------------
  typedef enum logic [2:0] {
    CODE_OFF_LO = 3'h0,
    CODE_AA = 3'h1,
    CODE_BB = 3'h2,
    CODE_CC = 3'h3,
    CODE_AB = 3'h4,
    CODE_BC = 3'h5,
    CODE_AC = 3'h6,
    CODE_OFF_HI = 3'h7
  } eps_code_t;

  // ----------------------------------------
  // Register select after address decode
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEL_CTRL = 2'h0,
    SEL_STATUS = 2'h1,
    SEL_NONE = 2'h2
  } eps_sel_t;

  // ----------------------------------------
  // Whole module state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] pin_code;
    logic [2:0] code;
    logic [2:0] inj;
    logic [2:0] det;
    logic ovr;
    logic [2:0] sw_code;
    logic aw_held;
    eps_sel_t aw_sel;
    logic w_held;
    logic [7:0] w_byte;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } eps_state_t;

endpackage

// *** hw/eps_decoder.sv ***
// Our own choices: the register addresses and the AXI4-Lite slave port.
`include "eps_defines.svh"

module eps_decoder #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Code pins from the isolator
  input wire logic [2:0] config_select_code,
  // Amplifier enables, near the electrode element
  output logic inject_enable_a,
  output logic inject_enable_b,
  output logic inject_enable_c,
  output logic detect_enable_a,
  output logic detect_enable_b,
  output logic detect_enable_c,
  // Amplifier enables, in the multiplexer box, bit 0 is A
  output logic [2:0] inject_enable_box,
  output logic [2:0] detect_enable_box,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W < `EPS_MIN_ADDR_W) begin : g_addr_check
    $error("eps_decoder: ADDR_W too small for the register map");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Returns {detect[2:0], inject[2:0]}, bit 0 is channel A, one-hot per side, all zero for the off codes
  function automatic logic [5:0] pair_decode(input logic [2:0] c);
    logic [5:0] e;
    e = 6'h00;
    case (eps_pkg::eps_code_t'(c))
      eps_pkg::CODE_AA: e = {3'h1, 3'h1};
      eps_pkg::CODE_BB: e = {3'h2, 3'h2};
      eps_pkg::CODE_CC: e = {3'h4, 3'h4};
      eps_pkg::CODE_AB: e = {3'h2, 3'h1};
      eps_pkg::CODE_BC: e = {3'h4, 3'h2};
      eps_pkg::CODE_AC: e = {3'h4, 3'h1};
      default: e = 6'h00;
    endcase
    return e;
  endfunction

  // Word decode only; byte lanes below bit 2 are ignored
  function automatic eps_pkg::eps_sel_t addr_sel(input logic [ADDR_W-1:0] a);
    eps_pkg::eps_sel_t s;
    s = eps_pkg::SEL_NONE;
    if (a[ADDR_W-1:2] == (ADDR_W-2)'(`EPS_REG_CTRL_OFS >> 2))
      s = eps_pkg::SEL_CTRL;
    else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`EPS_REG_STATUS_OFS >> 2))
      s = eps_pkg::SEL_STATUS;
    return s;
  endfunction

  eps_pkg::eps_state_t q;
  eps_pkg::eps_state_t d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [2:0] chosen;
    logic [31:0] rd;
    eps_pkg::eps_sel_t rsel;
    chosen = 3'h0;
    rd = 32'h0000_0000;
    rsel = eps_pkg::SEL_NONE;
    d = q;

    // Pins are asynchronous; the whole word must agree so a skewed
    // transition never shows an intermediate pairing
    d.s1 = config_select_code;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.pin_code = q.s3;
    end

    // Software may override the pins for bench-top checks
    chosen = q.ovr ? q.sw_code : q.pin_code;
    d.code = chosen;
    {d.det, d.inj} = pair_decode(chosen);

    // Write address and data, in either order
    if (awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.aw_sel = addr_sel(awaddr);
    end
    if (wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.w_byte = wdata[7:0];
      d.w_strb0 = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `EPS_RESP_OKAY;
      case (q.aw_sel)
        eps_pkg::SEL_CTRL: begin
          if (q.w_strb0) begin
            d.ovr = q.w_byte[`EPS_CTRL_OVR_BIT];
            d.sw_code = q.w_byte[`EPS_CTRL_CODE_LSB +: `EPS_CODE_W];
          end
        end
        // Status is read-only; writes are accepted and dropped
        eps_pkg::SEL_STATUS: d.bresp = `EPS_RESP_OKAY;
        default: d.bresp = `EPS_RESP_SLVERR;
      endcase
    end
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;

    // Read channel
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      rsel = addr_sel(araddr);
      d.rvalid = 1'b1;
      d.rresp = `EPS_RESP_OKAY;
      case (rsel)
        eps_pkg::SEL_CTRL: begin
          rd[`EPS_CTRL_OVR_BIT] = q.ovr;
          rd[`EPS_CTRL_CODE_LSB +: `EPS_CODE_W] = q.sw_code;
        end
        eps_pkg::SEL_STATUS: begin
          rd[`EPS_STAT_CODE_LSB +: `EPS_CODE_W] = q.code;
          rd[`EPS_STAT_INJ_LSB +: 3] = q.inj;
          rd[`EPS_STAT_DET_LSB +: 3] = q.det;
          rd[`EPS_STAT_PIN_LSB +: `EPS_CODE_W] = q.pin_code;
        end
        default: d.rresp = `EPS_RESP_SLVERR;
      endcase
      d.rdata = rd;
    end
    d.arready = !d.rvalid;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // One flop per channel feeds both amplifiers so they cannot split
  assign inject_enable_a = q.inj[0];
  assign inject_enable_b = q.inj[1];
  assign inject_enable_c = q.inj[2];
  assign detect_enable_a = q.det[0];
  assign detect_enable_b = q.det[1];
  assign detect_enable_c = q.det[2];
  assign inject_enable_box = q.inj;
  assign detect_enable_box = q.det;
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pin_agreed;
    !q.ovr && (q.s2 == q.s3);
  endsequence

  sequence s_pin_held;
    s_pin_agreed ##1 !q.ovr;
  endsequence

  AST_PIN_CODE_APPLIED: assert property (
    s_pin_held |=> q.code == $past(q.s3, 2))
    else $error("Agreed pin code not applied two cycles later");

  AST_STRAIGHT_PAIRS: assert property (
    (q.code inside {3'h1, 3'h2, 3'h3}) |-> (q.inj == q.det) && $onehot(q.inj)
      && (q.inj == 3'(1 << (q.code - 3'h1))))
    else $error("Transversal code drives the wrong pair");

  AST_CROSS_PAIRS: assert property (
    (q.code == 3'h4 |-> q.inj == 3'h1 && q.det == 3'h2) and
    (q.code == 3'h5 |-> q.inj == 3'h2 && q.det == 3'h4) and
    (q.code == 3'h6 |-> q.inj == 3'h1 && q.det == 3'h4))
    else $error("Vertical code drives the wrong pair");

  AST_OFF_CODES: assert property (
    (q.code == 3'h0 || q.code == 3'h7) |-> (q.inj == 3'h0) && (q.det == 3'h0))
    else $error("Off code leaves an amplifier enabled");

  AST_NEAR_BOX_TOGETHER: assert property (
    inject_enable_box == {inject_enable_c, inject_enable_b, inject_enable_a}
      && detect_enable_box == {detect_enable_c, detect_enable_b, detect_enable_a})
    else $error("Near and box amplifier enables differ");

  AST_ONE_PER_SIDE: assert property (
    $onehot0(q.inj) && $onehot0(q.det) && ($onehot(q.inj) == $onehot(q.det)))
    else $error("More than one enable on a side");

  // Decode of the applied code, for the deselect check only
  logic [5:0] cur_pair;
  assign cur_pair = pair_decode(q.code);

  AST_DESELECT_OFF: assert property (
    $changed(q.code) |-> ((q.inj & ~cur_pair[2:0]) == 3'h0)
      && ((q.det & ~cur_pair[5:3]) == 3'h0))
    else $error("Deselected channel still enabled");

  AST_NO_HISTORY: assert property (
    $stable(q.code) [*2] |-> $stable(q.inj) && $stable(q.det))
    else $error("Enables changed without a code change");

  // ----------------------------------------
  // Pin filter, override and bus answers
  // ----------------------------------------
  // A half-settled pin word must never reach the decode
  AST_PIN_FILTER_WAITS: assert property (
    (q.s2 != q.s3) |=> $stable(q.pin_code))
    else $error("Pin code accepted before the synchroniser agreed");

  // Override bypasses the pin path and its filter delay
  AST_OVR_CODE_APPLIED: assert property (
    q.ovr |=> q.code == $past(q.sw_code))
    else $error("Software code not applied under override");

  sequence s_write_pair;
    q.aw_held && q.w_held && !q.bvalid;
  endsequence

  AST_WRITE_ANSWERED: assert property (
    s_write_pair |=> q.bvalid && !q.aw_held && !q.w_held)
    else $error("Write not answered one cycle after both halves");

  // Partial writes that miss byte 0 leave the selection alone
  AST_CTRL_STROBE_GATED: assert property (
    s_write_pair ##0 (q.aw_sel == eps_pkg::SEL_CTRL && !q.w_strb0)
      |=> $stable(q.ovr) && $stable(q.sw_code))
    else $error("Control changed by a write without byte 0");

  AST_UNMAPPED_SLVERR: assert property (
    s_write_pair ##0 (q.aw_sel == eps_pkg::SEL_NONE) |=> q.bresp == `EPS_RESP_SLVERR)
    else $error("Unmapped write not answered with an error");

  // One register stage: read data stand right after the address
  AST_READ_ONE_CYCLE: assert property (
    arvalid && q.arready |=> q.rvalid && !q.arready)
    else $error("Read not answered right after the address");

endmodule

// *** bench/eps_mcu_model.sv ***
// ----------------------------------------
// Controller behind the isolator
// ----------------------------------------
module eps_mcu_model (
  // Clock
  input wire logic aclk,
  // Requested configuration
  input wire logic [2:0] code_cmd,
  // Isolated code pins
  output logic [2:0] config_select_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // Only three level pins cross; they stay put between changes
  initial config_select_code = 3'h0;
  always @(posedge aclk) config_select_code <= code_cmd;
endmodule

// *** bench/test_electrode_pair_select_decoder.sv ***
`include "eps_defines.svh"
module test_electrode_pair_select_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [2:0] code_cmd = 3'h0;
  logic [2:0] pins, inj_box, det_box;
  logic ia, ib, ic, da, db, dc;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] seed = 8'h2a;
  int error_cnt = 0;
  int checks = 0;

  initial begin
    forever #5 aclk = ~aclk;
  end

  eps_mcu_model mcu_u (.aclk(aclk), .code_cmd(code_cmd), .config_select_code(pins));

  eps_decoder dut_u (.aclk(aclk), .aresetn(aresetn), .config_select_code(pins),
    .inject_enable_a(ia), .inject_enable_b(ib), .inject_enable_c(ic),
    .detect_enable_a(da), .detect_enable_b(db), .detect_enable_c(dc),
    .inject_enable_box(inj_box), .detect_enable_box(det_box),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic logic [5:0] exp_en(input logic [2:0] c);
    case (c)
      3'h1: return 6'h09;
      3'h2: return 6'h12;
      3'h3: return 6'h24;
      3'h4: return 6'h11;
      3'h5: return 6'h22;
      3'h6: return 6'h21;
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic [33:0] status(input logic [2:0] c);
    logic [5:0] e;
    e = exp_en(c);
    return {2'h0, 17'h0, c, 1'b0, e[5:3], 1'b0, e[2:0], 1'b0, c};
  endfunction

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp(input logic [33:0] exp, input logic [33:0] act);
    checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t exp %h got %h", $time, exp, act);
    end
  endtask

  task automatic check_en(input logic [2:0] c);
    cmp({28'h0, exp_en(c)}, {28'h0, dc, db, da, ic, ib, ia});
    cmp({28'h0, exp_en(c)}, {28'h0, det_box, inj_box});
  endtask

  task automatic check_rd(input logic [33:0] exp);
    cmp(exp, {rresp, rdata});
  endtask

  task automatic check_wr(input logic [1:0] exp);
    cmp({32'h0, exp}, {32'h0, bresp});
  endtask

  // Pins need five edges through the synchroniser and filter
  task automatic set_pins(input logic [2:0] c);
    code_cmd <= c;
    repeat (8) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    rq.push_back(exp);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  always @(posedge aclk) begin
    if (rvalid && rready) check_rd(rq.pop_front());
    if (bvalid && bready) check_wr(bq.pop_front());
  end

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check_en(3'h0);
    for (int i = 7; i >= 0; i--) begin
      set_pins(i[2:0]);
      check_en(i[2:0]);
      rd(12'h004, status(i[2:0]));
    end
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      set_pins(seed[2:0]);
      check_en(seed[2:0]);
    end
    set_pins(3'h2);
    wr(12'h000, 32'h51, 4'hf, `EPS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check_en(3'h5);
    rd(12'h000, {`EPS_RESP_OKAY, 32'h51});
    // Byte 0 masked off: control must keep its value
    wr(12'h000, 32'h0, 4'he, `EPS_RESP_OKAY);
    rd(12'h000, {`EPS_RESP_OKAY, 32'h51});
    check_en(3'h5);
    wr(12'h004, 32'hffff, 4'hf, `EPS_RESP_OKAY);
    rd(12'h008, {`EPS_RESP_SLVERR, 32'h0});
    wr(12'h008, 32'h0, 4'hf, `EPS_RESP_SLVERR);
    wr(12'h000, 32'h0, 4'hf, `EPS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check_en(3'h2);
    // Mid-run reset drops every enable; the override is already off here
    set_pins(3'h3);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    check_en(3'h0);
    aresetn <= 1'b1;
    set_pins(3'h3);
    check_en(3'h3);
    repeat (2) @(posedge aclk);
    close_out();
  end
endmodule
